// ===== shared/slotcap_map.vh
// register map constants for the slot capability configuration bits
`ifndef SLOTCAP_MAP_VH
`define SLOTCAP_MAP_VH
`define SLOTCAP_GCTL_OFFSET      8'hD4
`define SLOTCAP_BIT_SURPRISE     13
`define SLOTCAP_BIT_POWER_LAMP   12
`define SLOTCAP_BIT_ATTN_LAMP    11
`define SLOTCAP_BIT_LATCH_SENSOR 10
`define SLOTCAP_BIT_POWER_CTRL   9
`define SLOTCAP_BIT_ATTN_BUTTON  8
`define SLOTCAP_BIT_SLOT_IMPL    7
`define SLOTCAP_BIT_FAULT_INPUT  6
`define SLOTCAP_FIELD_HI         13
`define SLOTCAP_FIELD_LO         6
`define SLOTCAP_FIELD_MASK       32'h00003FC0
`define SLOTCAP_RESET_FIXED      8'h00
`endif

// ===== rtl/slotcap_cfg.v
// slot capability configuration bits 13:6 of the port general control register
`timescale 1ns/1ps
`default_nettype none
`include "slotcap_map.vh"

// Behaviour
// (R1) bit 13 drives surprise-removal capability
// (R2) bits 13,7 default to strap pin
// (R3) bit 12 drives power lamp present
// (R4) bit 11 drives attention lamp present
// (R5) bit 10 drives latch sensor present
// (R6) bit 9 drives power controller present
// (R7) bit 8 drives attention button present
// (R8) bit 7 drives slot implemented bit
// (R9) bit 6 gates the power fault pin
// (R10) bits software writable, memory loaded, reset
// (R11) fundamental reset restores defaults
// (R12) writes show at once in capabilities
module slotcap_cfg (
  // clock and fundamental reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // strap and power fault pins
  input  wire        i_port_strap_pin,
  input  wire        i_power_fault_pin,
  // configuration register access at the general control offset
  input  wire [7:0]  i_cfg_addr,
  input  wire        i_cfg_wr,
  input  wire [31:0] i_cfg_wdata,
  input  wire [3:0]  i_cfg_be,
  output reg  [31:0] o_cfg_rdata,
  // serial configuration memory load
  input  wire        i_eeprom_load,
  input  wire [31:0] i_eeprom_data,
  // capability fields
  output wire        o_cap_surprise_removal,
  output wire        o_cap_power_lamp,
  output wire        o_cap_attention_lamp,
  output wire        o_cap_latch_sensor,
  output wire        o_cap_power_controller,
  output wire        o_cap_attention_button,
  output wire        o_cap_slot_implemented,
  // qualified power fault for the reference clock output logic
  output wire        o_power_fault_honoured
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [1:0] pin_raw;
  wire [1:0] pin_sync;
  wire       strap_level;
  wire       fault_level;

  // both pins come from outside the clock domain
  assign pin_raw = {i_power_fault_pin, i_port_strap_pin};

  genvar pi;
  generate
    for (pi = 0; pi < 2; pi = pi + 1) begin : g_sync
      reg [1:0] sync_reg;

      // two stages; only the second stage is read by logic
      always @(posedge i_clk) begin
        sync_reg <= {sync_reg[0], pin_raw[pi]};
      end

      assign pin_sync[pi] = sync_reg[1];
    end
  endgenerate

  // settled pin levels
  assign strap_level = pin_sync[0];
  assign fault_level = pin_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // field layout
  // place of the stored field in the 32-bit word
  localparam integer FIELD_LO = `SLOTCAP_FIELD_LO;
  localparam integer FIELD_HI = `SLOTCAP_FIELD_HI;
  localparam integer FIELD_W  = FIELD_HI - FIELD_LO + 1;
  localparam integer TOP_W    = 31 - FIELD_HI;

  // position of each configuration bit inside the stored field
  localparam integer IDX_SURPRISE     = `SLOTCAP_BIT_SURPRISE - FIELD_LO;
  localparam integer IDX_POWER_LAMP   = `SLOTCAP_BIT_POWER_LAMP - FIELD_LO;
  localparam integer IDX_ATTN_LAMP    = `SLOTCAP_BIT_ATTN_LAMP - FIELD_LO;
  localparam integer IDX_LATCH_SENSOR = `SLOTCAP_BIT_LATCH_SENSOR - FIELD_LO;
  localparam integer IDX_POWER_CTRL   = `SLOTCAP_BIT_POWER_CTRL - FIELD_LO;
  localparam integer IDX_ATTN_BUTTON  = `SLOTCAP_BIT_ATTN_BUTTON - FIELD_LO;
  localparam integer IDX_SLOT_IMPL    = `SLOTCAP_BIT_SLOT_IMPL - FIELD_LO;
  localparam integer IDX_FAULT_INPUT  = `SLOTCAP_BIT_FAULT_INPUT - FIELD_LO;

  // bits whose default is the strap level of this port
  localparam [7:0] STRAP_MASK = (8'h01 << IDX_SURPRISE) | (8'h01 << IDX_SLOT_IMPL);
  // defaults of the bits that do not follow the strap
  localparam [7:0] FIXED_DFLT = `SLOTCAP_RESET_FIXED;

  // one-hot codes for the source of the next field value
  localparam [3:0] SRC_HOLD  = 4'h1;
  localparam [3:0] SRC_DFLT  = 4'h2;
  localparam [3:0] SRC_LOAD  = 4'h4;
  localparam [3:0] SRC_WRITE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // access decode
  wire wr_hit;
  wire rd_hit;

  // only the general control word maps; writes elsewhere are ignored
  assign wr_hit = i_cfg_wr && (i_cfg_addr == `SLOTCAP_GCTL_OFFSET); // R10
  assign rd_hit = (i_cfg_addr == `SLOTCAP_GCTL_OFFSET);             // R10

  ////////////////////////////////////////////////////////////////////////////
  // source selection
  reg       rst_seen_reg;
  reg [3:0] src_sel;

  // strap default wins, then memory load, then software write
  always @* begin
    src_sel = SRC_HOLD;
    if (rst_seen_reg) begin
      src_sel = SRC_DFLT; // R2
    end else if (i_eeprom_load) begin
      src_sel = SRC_LOAD; // R10
    end else if (wr_hit) begin
      src_sel = SRC_WRITE; // R10
    end
  end

  // marks the first edge after reset, where the strap level is taken
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      rst_seen_reg <= 1'b1; // R11
    end else begin
      rst_seen_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration bits, one slice per bit
  wire [7:0] cfg_bits;
  wire [7:0] wr_image;
  wire [7:0] ld_image;

  // write and memory images of the field
  assign wr_image = i_cfg_wdata[FIELD_HI:FIELD_LO];
  assign ld_image = i_eeprom_data[FIELD_HI:FIELD_LO];

  genvar gi;
  generate
    for (gi = 0; gi < FIELD_W; gi = gi + 1) begin : g_bit
      // byte lane that carries this bit on a write
      localparam integer LANE = (gi + FIELD_LO) / 8;

      reg  bit_reg;
      reg  bit_next;
      wire bit_dflt;
      wire bit_lane_on;

      // default is the strap level for two bits, fixed for the rest
      assign bit_dflt    = STRAP_MASK[gi] ? strap_level : FIXED_DFLT[gi]; // R2
      // bits 13:8 sit in lane 1, bits 7:6 in lane 0
      assign bit_lane_on = i_cfg_be[LANE];

      // next value of this bit
      always @* begin
        case (src_sel)
          // nothing requested
          SRC_HOLD: begin
            bit_next = bit_reg;
          end
          // first edge after reset
          SRC_DFLT: begin
            bit_next = bit_dflt; // R2
          end
          // serial memory image
          SRC_LOAD: begin
            bit_next = ld_image[gi]; // R10
          end
          // software write, per byte lane
          SRC_WRITE: begin
            bit_next = bit_lane_on ? wr_image[gi] : bit_reg; // R10 R12
          end
          default: begin
            bit_next = bit_reg;
          end
        endcase
      end

      // fixed default while reset is held
      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          bit_reg <= FIXED_DFLT[gi]; // R11
        end else begin
          bit_reg <= bit_next;
        end
      end

      // gather the slices into one field
      assign cfg_bits[gi] = bit_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data
  wire [31:0] rd_word;

  // field in place; the other bits of the word read as zero here
  assign rd_word = {{TOP_W{1'b0}}, cfg_bits, {FIELD_LO{1'b0}}};

  // registered; a read shows the value stored before its edge
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cfg_rdata <= 32'h00000000; // R11
    end else if (rd_hit) begin
      o_cfg_rdata <= rd_word; // R10
    end else begin
      o_cfg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capability fields follow the stored bits directly
  assign o_cap_surprise_removal = cfg_bits[IDX_SURPRISE];     // R1 R12
  assign o_cap_power_lamp       = cfg_bits[IDX_POWER_LAMP];   // R3
  assign o_cap_attention_lamp   = cfg_bits[IDX_ATTN_LAMP];    // R4
  assign o_cap_latch_sensor     = cfg_bits[IDX_LATCH_SENSOR]; // R5
  assign o_cap_power_controller = cfg_bits[IDX_POWER_CTRL];   // R6
  assign o_cap_attention_button = cfg_bits[IDX_ATTN_BUTTON];  // R7
  assign o_cap_slot_implemented = cfg_bits[IDX_SLOT_IMPL];    // R8

  // fault pin ignored unless the fault input is declared present
  assign o_power_fault_honoured = cfg_bits[IDX_FAULT_INPUT]
                                & fault_level; // R9

endmodule // slotcap_cfg
`default_nettype wire

// ===== dv/scc_cfg_assertions.sv
// checker for the slot capability configuration bits
`timescale 1ns/1ps
`default_nettype none
module scc_chk(input wire logic i_clk,i_sys_rst,i_port_strap_pin,i_cfg_wr,i_eeprom_load,
  o_cap_surprise_removal,o_cap_power_lamp,o_cap_attention_lamp,o_cap_latch_sensor,
  o_cap_power_controller,o_cap_attention_button,o_cap_slot_implemented,o_power_fault_honoured,
  input wire logic [7:0] i_cfg_addr,input wire logic [31:0] i_cfg_wdata,i_eeprom_data,o_cfg_rdata);
  // capability fields as bits 13:7, and a write that lands
  wire [6:0] c={o_cap_surprise_removal,o_cap_power_lamp,o_cap_attention_lamp,o_cap_latch_sensor,
    o_cap_power_controller,o_cap_attention_button,o_cap_slot_implemented};
  // a request in the first cycle after reset loses to the strap default
  logic rst_d_reg=1'b1;
  always @(posedge i_clk) rst_d_reg<=i_sys_rst;
  wire w=i_cfg_wr&&i_cfg_addr==8'hD4&&!i_eeprom_load&&!rst_d_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_sr; w|=>c[6]==$past(i_cfg_wdata[13]); endproperty
  a_sr: assert property(p_sr) else $error("surprise");
  property p_hi; w|=>c[5:1]==$past(i_cfg_wdata[12:8]); endproperty
  a_hi: assert property(p_hi) else $error("lamps");
  property p_si; w|=>c[0]==$past(i_cfg_wdata[7]); endproperty
  a_si: assert property(p_si) else $error("slot");
  property p_pf; w&&!i_cfg_wdata[6]|=>!o_power_fault_honoured; endproperty
  a_pf: assert property(p_pf) else $error("fault");
  property p_ld; i_eeprom_load&&!rst_d_reg|=>c==$past(i_eeprom_data[13:7]); endproperty
  a_ld: assert property(p_ld) else $error("load");
  property p_st; $fell(i_sys_rst)|->##1 {c[6],c[0]}=={2{i_port_strap_pin}}&&c[5:1]==5'h0;
  endproperty
  a_st: assert property(p_st) else $error("strap");
  property p_rs; disable iff (1'b0) i_sys_rst|=>o_cfg_rdata==32'h0&&c==7'h0; endproperty
  a_rs: assert property(p_rs) else $error("reset");
  property p_rd; w##1(i_cfg_addr==8'hD4&&!i_cfg_wr&&!i_eeprom_load)|=>o_cfg_rdata[13:7]==c;
  endproperty
  a_rd: assert property(p_rd) else $error("read");
  cover property(w); cover property(i_eeprom_load); cover property($fell(i_sys_rst));
endmodule // scc_chk
`default_nettype wire

// ===== dv/test_slotcap_cfg.sv
// self-checking bench for the slot capability configuration bits
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin n_tests++; if((a)!==(b)) begin miscompares++; \
$display("MISMATCH %0t %h %h",$time,a,b); end end
module test_slotcap_cfg;
  logic i_clk=0,i_sys_rst=1,i_cfg_wr=0,i_eeprom_load=0,i_port_strap_pin=1,i_power_fault_pin=1;
  logic [7:0] i_cfg_addr=8'hD4;
  logic [31:0] i_cfg_wdata=32'h0,o_cfg_rdata;
  wire o_cap_surprise_removal,o_cap_power_lamp,o_cap_attention_lamp,o_cap_latch_sensor,
    o_cap_power_controller,o_cap_attention_button,o_cap_slot_implemented,o_power_fault_honoured;
  wire [6:0] caps={o_cap_surprise_removal,o_cap_power_lamp,o_cap_attention_lamp,
    o_cap_latch_sensor,o_cap_power_controller,o_cap_attention_button,o_cap_slot_implemented};
  int miscompares=0,n_tests=0;
  slotcap_cfg i_dut(.*,.i_cfg_be(4'hF),.i_eeprom_data(i_cfg_wdata));
  initial forever #25 i_clk=~i_clk;
  // one access held for one cycle, then two idle cycles at the register address
  task op(input [7:0] a,input [31:0] d,input w,l);
    @(negedge i_clk) {i_cfg_addr,i_cfg_wdata,i_cfg_wr,i_eeprom_load}={a,d,w,l};
    repeat(2) @(negedge i_clk) {i_cfg_addr,i_cfg_wr,i_eeprom_load}={8'hD4,2'h0};
  endtask
  task t_walk;
    for(int i=6;i<14;i++) begin op(8'hD4,32'h1<<i,1,0);
      `CHK(o_cfg_rdata,32'h1<<i)
      `CHK(caps,(i>6)?7'h1<<(i-7):7'h0)
    end
    op(8'hD0,32'h0,1,0); `CHK(o_cfg_rdata,32'h2000)
  endtask
  task t_fault; op(8'hD4,32'h40,1,0);
    `CHK(o_power_fault_honoured,1'b1)
    i_power_fault_pin=0; repeat(3) @(negedge i_clk);
    `CHK(o_power_fault_honoured,1'b0)
    i_power_fault_pin=1; op(8'hD4,32'h0,1,0);
    `CHK(o_power_fault_honoured,1'b0)
  endtask
  task t_load; op(8'hD4,32'h1480,0,1);
    `CHK(o_cfg_rdata,32'h1480)
    `CHK(caps,7'h29)
  endtask
  task t_reset(input s); i_sys_rst=1; i_port_strap_pin=s; repeat(5) @(negedge i_clk);
    `CHK(o_cfg_rdata,32'h0)
    `CHK(caps,7'h0)
    i_sys_rst=0; repeat(3) @(negedge i_clk);
    `CHK(o_cfg_rdata,s?32'h2080:32'h0)
    `CHK(caps,s?7'h41:7'h0)
  endtask
  task stop_test; $display("tests %0d miscompares %0d",n_tests,miscompares);
    if(miscompares==0&&n_tests>0) $display("No errors found");
    else $display("Errors were found");
    $finish; endtask
  initial begin t_reset(1); t_walk; t_fault; t_load; t_reset(0); stop_test; end
  initial begin #20000; miscompares++; stop_test; end
endmodule // test_slotcap_cfg
bind slotcap_cfg scc_chk u_chk(.*);
`default_nettype wire
